// ===== rtl/epso_pkg.sv
// constants, field layouts and types shared by the energy pulse and status block
package epso_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int        CLK_PERIOD_NS = 8;
  localparam int        CF_WIDTH_NS   = 40;
  localparam int        LR_WIDTH_NS   = 64;
  localparam logic [7:0] CF_WIDTH_CYC =
    8'((CF_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] LR_WIDTH_CYC =
    8'((LR_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ****************************************************************
  // measurement thresholds
  // ****************************************************************
  localparam int          MISMATCH_SHIFT = 4;   // 1/16 of the larger current, 6.25 %
  localparam logic [15:0] VOLT_MIN       = 16'h0040;
  localparam logic [31:0] LR_THR_0       = 32'h0100_0000;
  localparam logic [31:0] LR_THR_1       = 32'h0080_0000;
  localparam logic [31:0] LR_THR_2       = 32'h0040_0000;
  localparam logic [31:0] LR_THR_3       = 32'h0020_0000;
  localparam logic [4:0]  CF_SHIFT_LO    = 5'h04;
  localparam logic [4:0]  CF_SHIFT_HI    = 5'h06;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int         ADDR_W        = 8;
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_INT_STAT = 8'h08;
  localparam logic [7:0] ADDR_INT_MASK = 8'h0C;
  localparam logic [7:0] ADDR_ENERGY   = 8'h10;
  localparam int          CTRL_ENABLE  = 0;
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0001;
  localparam int ST_FAULT    = 0;
  localparam int ST_NEG      = 1;
  localparam int ST_MISMATCH = 2;
  localparam int ST_NO_VOLT  = 3;
  localparam int ST_UV       = 4;
  localparam int ST_GAIN     = 5;
  localparam int ST_CAL      = 6;
  localparam int ST_RATE_LO  = 7;
  localparam int ST_RATE_HI  = 8;
  localparam int EV_FAULT = 0;
  localparam int EV_NEG   = 1;
  localparam int EV_CF    = 2;
  localparam int EV_UV    = 3;
  localparam int EV_W     = 4;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic [1:0] rate_sel;
    logic       cal_sel;
    logic       gain_sel;
  } epso_cfg_t;

  typedef struct packed {
    logic               valid;
    logic signed [23:0] power;
    logic        [15:0] cur_a;
    logic        [15:0] cur_b;
    logic        [15:0] volt;
  } epso_sample_t;

  typedef enum logic [1:0] { WR_IDLE = 2'b01, WR_RESP = 2'b10 } epso_wr_state_t;
  typedef enum logic [1:0] { RD_IDLE = 2'b01, RD_DATA = 2'b10 } epso_rd_state_t;

endpackage

// ===== rtl/epso_pulse_gen.sv
// energy accumulator that fires once per threshold of accumulated magnitude
`timescale 1ns/1ns
module epso_pulse_gen
  import epso_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic        run,
  input  wire logic        step_valid,
  input  wire logic [23:0] step,
  input  wire logic [31:0] threshold,
  output logic             fire
);

  logic [31:0] acc;
  logic [31:0] next_acc;
  logic        next_fire;
  logic [32:0] sum;

  always_comb
  begin
    sum       = {9'h000, step} + {1'b0, acc};
    next_acc  = acc;
    next_fire = 1'b0;
    // accumulation stops entirely while not running
    if (run && step_valid)
    begin
      if (sum >= {1'b0, threshold})
      begin
        next_acc  = 32'(sum - {1'b0, threshold});
        next_fire = 1'b1;
      end
      else
      begin
        next_acc = sum[31:0];
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      acc  <= 32'h0000_0000;
      fire <= 1'b0;
    end
    else if (ce)
    begin
      acc  <= next_acc;
      fire <= next_fire;
    end
  end

endmodule

// ===== rtl/epso_top.sv
// energy pulse outputs, fault and reverse-power indicators with an axi4-lite slave
// Functional notes
// - fault goes high while the two currents differ by more than 6.25 %
// - fault also goes high when no line voltage is present
// - fault returns to 0 once neither condition is detected
// - reverse-power flag goes high when measured power is negative
// - reverse-power flag does not latch; clears on positive power
// - reverse-power flag changes only together with a calibration pulse
// - two rate-select inputs choose one of four low-rate frequencies
// - gain-select input sets current channel gain to 1 or 16
// - calibration-rate input chooses the calibration pulse frequency
// - calibration pulse is active high, rate follows instantaneous power
// - two low-rate outputs alternate, conveying average power for counters
// - under supply undervoltage, accumulation stops and all pulse outputs are off
//
// The register addresses and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ns
module epso_top
  import epso_pkg::*;
(
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               ce,
  input  wire logic               rate_select_hi,
  input  wire logic               rate_select_lo,
  input  wire logic               cal_rate_select,
  input  wire logic               current_gain_select,
  input  wire logic               supply_low,
  input  wire epso_sample_t       sample,
  output logic                    calibration_pulse_out,
  output logic                    low_rate_pulse_a,
  output logic                    low_rate_pulse_b,
  output logic                    fault_flag,
  output logic                    negative_power_flag,
  output logic                    gain_x16,
  output logic                    irq,
  input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [ADDR_W-1:0]  s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready
);

  function automatic logic [31:0] lr_threshold(input logic [1:0] rate);
    case (rate)
      2'h0:    lr_threshold = LR_THR_0;
      2'h1:    lr_threshold = LR_THR_1;
      2'h2:    lr_threshold = LR_THR_2;
      default: lr_threshold = LR_THR_3;
    endcase
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a == ADDR_CTRL) || (a == ADDR_STATUS) || (a == ADDR_INT_STAT)
          || (a == ADDR_INT_MASK) || (a == ADDR_ENERGY);
  endfunction

  // ****************************************************************
  // configuration synchroniser
  // ****************************************************************
  logic [3:0] cfg_raw;
  logic [3:0] sync1;
  logic [3:0] sync2;
  epso_cfg_t  cfg;

  assign cfg_raw = {rate_select_hi, rate_select_lo, cal_rate_select, current_gain_select};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_sync
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
        end
        else if (ce)
        begin
          sync1[gi] <= cfg_raw[gi];
          sync2[gi] <= sync1[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cfg <= '0;
    else if (ce)
      cfg <= epso_cfg_t'(sync2);
  end

  // ****************************************************************
  // measurement, fault and reverse power
  // ****************************************************************
  logic [23:0] pwr_mag;
  logic        pwr_neg;
  logic [15:0] cur_hi;
  logic [15:0] cur_lo;
  logic        mismatch_now;
  logic        no_volt_now;
  logic        run;
  logic [31:0] ctrl;
  logic [31:0] lr_thr;
  logic [31:0] cf_thr;
  logic        cf_fire;
  logic        lr_fire;
  logic        cf_take;
  logic        lr_take;
  logic        mismatch;
  logic        no_volt;
  logic        next_mismatch;
  logic        next_no_volt;
  logic        next_fault;
  logic        next_neg;

  assign pwr_neg = sample.power[23];
  assign pwr_mag = pwr_neg ? 24'(-sample.power) : 24'(sample.power);
  assign cur_hi  = (sample.cur_a > sample.cur_b) ? sample.cur_a : sample.cur_b;
  assign cur_lo  = (sample.cur_a > sample.cur_b) ? sample.cur_b : sample.cur_a;
  assign mismatch_now = (cur_hi - cur_lo) > (cur_hi >> MISMATCH_SHIFT);
  assign no_volt_now  = sample.volt < VOLT_MIN;
  assign run     = ctrl[CTRL_ENABLE] && !supply_low;
  assign lr_thr  = lr_threshold(cfg.rate_sel);
  assign cf_thr  = lr_thr >> (cfg.cal_sel ? CF_SHIFT_HI : CF_SHIFT_LO);
  // a fire swallowed by undervoltage issues no pulse, so it may not move the flag either
  assign cf_take = ce && cf_fire && !supply_low;
  assign lr_take = ce && lr_fire;

  epso_pulse_gen u_cf_gen (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .ce         (ce),
    .run        (run),
    .step_valid (sample.valid),
    .step       (pwr_mag),
    .threshold  (cf_thr),
    .fire       (cf_fire)
  );

  epso_pulse_gen u_lr_gen (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .ce         (ce),
    .run        (run),
    .step_valid (sample.valid),
    .step       (pwr_mag),
    .threshold  (lr_thr),
    .fire       (lr_fire)
  );

  always_comb
  begin
    next_mismatch = mismatch;
    next_no_volt  = no_volt;
    if (sample.valid)
    begin
      next_mismatch = mismatch_now;
      next_no_volt  = no_volt_now;
    end
    next_fault = next_mismatch || next_no_volt;
    // sign sampled only at the calibration pulse, so the flag never toggles between pulses
    next_neg = (cf_fire && !supply_low) ? pwr_neg : negative_power_flag;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mismatch            <= 1'b0;
      no_volt             <= 1'b0;
      fault_flag          <= 1'b0;
      negative_power_flag <= 1'b0;
      gain_x16            <= 1'b0;
    end
    else if (ce)
    begin
      mismatch            <= next_mismatch;
      no_volt             <= next_no_volt;
      fault_flag          <= next_fault;
      negative_power_flag <= next_neg;
      gain_x16            <= cfg.gain_sel;
    end
  end

  // ****************************************************************
  // pulse shaping
  // ****************************************************************
  logic [7:0] cf_cnt;
  logic [7:0] lr_cnt;
  logic       lr_phase;
  logic [7:0] next_cf_cnt;
  logic [7:0] next_lr_cnt;
  logic       next_lr_phase;

  always_comb
  begin
    next_cf_cnt   = (cf_cnt != 8'h00) ? cf_cnt - 8'h01 : 8'h00;
    next_lr_cnt   = (lr_cnt != 8'h00) ? lr_cnt - 8'h01 : 8'h00;
    next_lr_phase = lr_phase;
    if (cf_fire)
      next_cf_cnt = CF_WIDTH_CYC;
    if (lr_fire)
    begin
      next_lr_cnt   = LR_WIDTH_CYC;
      next_lr_phase = !lr_phase;
    end
    if (supply_low)
    begin
      next_cf_cnt = 8'h00;
      next_lr_cnt = 8'h00;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cf_cnt                <= 8'h00;
      lr_cnt                <= 8'h00;
      lr_phase              <= 1'b0;
      calibration_pulse_out <= 1'b0;
      low_rate_pulse_a      <= 1'b0;
      low_rate_pulse_b      <= 1'b0;
    end
    else if (ce)
    begin
      cf_cnt                <= next_cf_cnt;
      lr_cnt                <= next_lr_cnt;
      lr_phase              <= next_lr_phase;
      calibration_pulse_out <= next_cf_cnt != 8'h00;
      low_rate_pulse_a      <= (next_lr_cnt != 8'h00) && next_lr_phase;
      low_rate_pulse_b      <= (next_lr_cnt != 8'h00) && !next_lr_phase;
    end
  end

  // ****************************************************************
  // register file and interrupt
  // ****************************************************************
  epso_wr_state_t        wr_state;
  epso_wr_state_t        next_wr_state;
  epso_rd_state_t        rd_state;
  epso_rd_state_t        next_rd_state;
  logic                  aw_got;
  logic                  w_got;
  logic [ADDR_W-1:0]     aw_addr;
  logic [31:0]           w_data;
  logic [3:0]            w_strb;
  logic [EV_W-1:0]       int_stat;
  logic [EV_W-1:0]       int_mask;
  logic [31:0]           energy;
  logic [31:0]           status;
  logic [EV_W-1:0]       events;
  logic                  uv_d;
  logic                  next_aw_got;
  logic                  next_w_got;
  logic [31:0]           next_ctrl;
  logic [EV_W-1:0]       next_int_stat;
  logic [EV_W-1:0]       next_int_mask;
  logic [EV_W-1:0]       w1c;
  logic [31:0]           next_rdata;
  logic [1:0]            next_rresp;
  logic [1:0]            next_bresp;

  always_comb
  begin
    status = 32'h0000_0000;
    status[ST_FAULT]    = fault_flag;
    status[ST_NEG]      = negative_power_flag;
    status[ST_MISMATCH] = mismatch;
    status[ST_NO_VOLT]  = no_volt;
    status[ST_UV]       = supply_low;
    status[ST_GAIN]     = cfg.gain_sel;
    status[ST_CAL]      = cfg.cal_sel;
    status[ST_RATE_LO]  = cfg.rate_sel[0];
    status[ST_RATE_HI]  = cfg.rate_sel[1];
    events = '0;
    events[EV_FAULT] = next_fault && !fault_flag;
    events[EV_NEG]   = next_neg != negative_power_flag;
    events[EV_CF]    = cf_fire;
    events[EV_UV]    = supply_low && !uv_d;
    next_aw_got   = aw_got || (s_axi_awvalid && s_axi_awready);
    next_w_got    = w_got || (s_axi_wvalid && s_axi_wready);
    next_wr_state = wr_state;
    next_ctrl     = ctrl;
    next_int_mask = int_mask;
    next_bresp    = s_axi_bresp;
    w1c           = '0;
    case (wr_state)
      WR_IDLE:
        if (aw_got && w_got)
        begin
          next_aw_got   = 1'b0;
          next_w_got    = 1'b0;
          next_wr_state = WR_RESP;
          next_bresp    = mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
          if (w_strb[0] && aw_addr == ADDR_CTRL)
            next_ctrl = {ctrl[31:8], w_data[7:0]};
          if (w_strb[0] && aw_addr == ADDR_INT_STAT)
            w1c = w_data[EV_W-1:0];
          if (w_strb[0] && aw_addr == ADDR_INT_MASK)
            next_int_mask = w_data[EV_W-1:0];
        end
      WR_RESP:
        if (s_axi_bready)
          next_wr_state = WR_IDLE;
      default:
        next_wr_state = WR_IDLE;
    endcase
    // a new event in the clearing cycle survives the clear
    next_int_stat = (int_stat & ~w1c) | events;
    next_rd_state = rd_state;
    next_rdata    = s_axi_rdata;
    next_rresp    = s_axi_rresp;
    case (rd_state)
      RD_IDLE:
        if (s_axi_arvalid && s_axi_arready)
        begin
          next_rd_state = RD_DATA;
          next_rresp    = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
          case (s_axi_araddr)
            ADDR_CTRL:     next_rdata = ctrl;
            ADDR_STATUS:   next_rdata = status;
            ADDR_INT_STAT: next_rdata = {{(32-EV_W){1'b0}}, int_stat};
            ADDR_INT_MASK: next_rdata = {{(32-EV_W){1'b0}}, int_mask};
            ADDR_ENERGY:   next_rdata = energy;
            default:       next_rdata = 32'h0000_0000;
          endcase
        end
      RD_DATA:
        if (s_axi_rready)
          next_rd_state = RD_IDLE;
      default:
        next_rd_state = RD_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_state      <= WR_IDLE;
      rd_state      <= RD_IDLE;
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      aw_addr       <= '0;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      ctrl          <= CTRL_RESET;
      int_stat      <= '0;
      int_mask      <= '0;
      energy        <= 32'h0000_0000;
      uv_d          <= 1'b0;
      irq           <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end
    else if (ce)
    begin
      wr_state      <= next_wr_state;
      rd_state      <= next_rd_state;
      aw_got        <= next_aw_got;
      w_got         <= next_w_got;
      if (s_axi_awvalid && s_axi_awready)
        aw_addr <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      ctrl          <= next_ctrl;
      int_stat      <= next_int_stat;
      int_mask      <= next_int_mask;
      energy        <= cf_fire ? energy + 32'h0000_0001 : energy;
      uv_d          <= supply_low;
      irq           <= |(next_int_stat & next_int_mask);
      s_axi_awready <= (next_wr_state == WR_IDLE) && !next_aw_got;
      s_axi_wready  <= (next_wr_state == WR_IDLE) && !next_w_got;
      s_axi_bvalid  <= next_wr_state == WR_RESP;
      s_axi_bresp   <= next_bresp;
      s_axi_arready <= next_rd_state == RD_IDLE;
      s_axi_rvalid  <= next_rd_state == RD_DATA;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  fault_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && sample.valid && (mismatch_now || no_volt_now) |=> fault_flag)
    else $error("fault flag missed a mismatch or missing voltage");
  fault_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && sample.valid && !mismatch_now && !no_volt_now |=> !fault_flag)
    else $error("fault flag stayed high after conditions cleared");
  neg_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cf_take && pwr_neg |=> negative_power_flag && calibration_pulse_out)
    else $error("negative power not flagged at calibration pulse");
  neg_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cf_take && !pwr_neg |=> !negative_power_flag)
    else $error("negative power flag latched");
  neg_timing_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !$stable(negative_power_flag) |-> $past(cf_take) && $rose(calibration_pulse_out))
    else $error("negative power flag moved without a calibration pulse");
  uv_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && supply_low |=> !calibration_pulse_out && !low_rate_pulse_a && !low_rate_pulse_b)
    else $error("pulse output active during undervoltage");
  gain_sync_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && current_gain_select) [*4] |=> gain_x16)
    else $error("gain select not applied after synchronisation");
  lr_excl_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !(low_rate_pulse_a && low_rate_pulse_b) and ($rose(low_rate_pulse_a) |-> $past(lr_take)))
    else $error("low-rate outputs overlap or fired without an energy step");

endmodule

// ===== tb/epso_counter_model.sv
// two-phase stepper or counter model driven by the low-rate pulse outputs
`timescale 1ns/1ns
module epso_counter_model
(
  input  wire logic        aclk,
  input  wire logic        low_rate_pulse_a,
  input  wire logic        low_rate_pulse_b,
  output logic      [15:0] steps_a = 16'h0,
  output logic      [15:0] steps_b = 16'h0,
  output logic             out_of_turn = 1'b0
);
  // ****************************************
  // step counting
  // ****************************************
  logic pa = 1'b0;
  logic pb = 1'b0;

  // a phase fired twice in a row loses a step on a real motor
  always @(posedge aclk)
  begin
    if (low_rate_pulse_a && !pa)
    begin
      steps_a <= steps_a + 16'h1;
      if (steps_a != steps_b)
        out_of_turn <= 1'b1;
    end
    if (low_rate_pulse_b && !pb)
    begin
      steps_b <= steps_b + 16'h1;
      if (steps_a != steps_b + 16'h1)
        out_of_turn <= 1'b1;
    end
    pa <= low_rate_pulse_a;
    pb <= low_rate_pulse_b;
  end
endmodule

// ===== tb/tb.sv
// self-checking bench for the energy pulse and status block
`timescale 1ns/1ns
module tb;
  import epso_pkg::*;
  // ****************************************
  // signals and bookkeeping
  // ****************************************
  logic         aclk = 1'b0;
  logic         aresetn = 1'b0;
  logic [1:0]   rsel = 2'h0;
  logic         csel = 1'b0;
  logic         gsel = 1'b0;
  logic         supply_low = 1'b0;
  epso_sample_t sample = '0;
  logic         cf, fa, fb, fault_flag, neg, gx16, irq;
  logic [7:0]   awaddr = 8'h00;
  logic [7:0]   araddr = 8'h00;
  logic [31:0]  wdata = 32'h0;
  logic [31:0]  rdata;
  logic         awvalid = 1'b0;
  logic         wvalid = 1'b0;
  logic         bready = 1'b0;
  logic         arvalid = 1'b0;
  logic         rready = 1'b0;
  logic         awready, wready, bvalid, arready, rvalid;
  logic [1:0]   bresp, rresp;
  logic [15:0]  steps_a, steps_b;
  logic         out_of_turn;
  logic         nf_p = 1'b0;
  logic         cf_p = 1'b0;
  logic [33:0]  qe[$];
  logic [31:0]  qm[$];
  logic [31:0]  lfsr = 32'h0001737D;
  int           n_fail = 0;
  int           n_compared = 0;
  int           cyc = 0;
  longint       sum = 0;

  always #4 aclk = ~aclk;

  epso_top dut_u (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .rate_select_hi(rsel[1]),
    .rate_select_lo(rsel[0]), .cal_rate_select(csel), .current_gain_select(gsel),
    .supply_low(supply_low), .sample(sample), .calibration_pulse_out(cf),
    .low_rate_pulse_a(fa), .low_rate_pulse_b(fb), .fault_flag(fault_flag),
    .negative_power_flag(neg), .gain_x16(gx16), .irq(irq), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  epso_counter_model pm_u (.aclk(aclk), .low_rate_pulse_a(fa), .low_rate_pulse_b(fb),
    .steps_a(steps_a), .steps_b(steps_b), .out_of_turn(out_of_turn));

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic cmp_bit(input string nm, input logic e, input logic s);
    n_compared++;
    if (s !== e)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, s);
    end
  endtask

  task automatic cmp_word(input string nm, input logic [33:0] e, input logic [33:0] s);
    n_compared++;
    if (s !== e)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (awvalid && !awready || wvalid && !wready);
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    cmp_word("bresp", {32'h0, er}, {32'h0, bresp});
  endtask

  // expected word is pushed already masked; the monitor masks what it sees
  task automatic rd(input logic [7:0] a, input logic [33:0] e, input logic [31:0] m);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    qe.push_back(e);
    qm.push_back(m);
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  task automatic smp(input logic [23:0] p, input logic [15:0] b, input logic [15:0] v);
    @(posedge aclk);
    sample <= {1'b1, p, 16'h03E8, b, v};
    @(posedge aclk);
    sample.valid <= 1'b0;
    repeat (10) @(posedge aclk);
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ****************************************
  // monitors
  // ****************************************
  always @(posedge aclk)
    if (rvalid && rready && qe.size() > 0)
      cmp_word("read", qe.pop_front(), {rresp, rdata & qm.pop_front()});

  always @(negedge aclk)
  begin
    if (neg !== nf_p)
      cmp_bit("neg_with_cf", 1'b1, cf & ~cf_p);
    nf_p = neg;
    cf_p = cf;
  end

  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      n_fail++;
      $display("CHECK FAILED timeout expected done seen hung");
      report_and_stop;
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    logic [23:0] p;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_CTRL, {RESP_OKAY, CTRL_RESET}, 32'hFFFFFFFF);
    rd(ADDR_STATUS, {RESP_OKAY, 32'h0}, 32'hFFFFFFFF);
    rd(8'h20, {RESP_SLVERR, 32'h0}, 32'hFFFFFFFF);
    wr(8'h20, 32'hFFFFFFFF, RESP_SLVERR);
    $display("test registers done");
    // 938 sits exactly on the 1/16 boundary of 1000
    for (int i = 0; i < 4; i++)
    begin
      smp(24'h0, i[0] ? 16'h03AA : 16'h0384, i[1] ? 16'h003F : 16'h0040);
      cmp_bit("fault", !i[0] || i[1], fault_flag);
    end
    $display("test fault done");
    wr(ADDR_INT_MASK, 32'h4, RESP_OKAY);
    for (int i = 0; i < 44; i++)
    begin
      lfsr = lfsr_next(lfsr);
      p = 24'h080000 + {5'h0, lfsr[18:0]};
      sum += p;
      smp((i >= 20 && i < 40) ? -p : p, 16'h03E8, 16'h0100);
      if (i == 39 || i == 43)
        cmp_bit("neg_flag", i == 39, neg);
    end
    cmp_bit("irq", 1'b1, irq);
    wr(ADDR_INT_STAT, 32'h4, RESP_OKAY);
    repeat (2) @(posedge aclk);
    cmp_bit("irq", 1'b0, irq);
    rd(ADDR_ENERGY, {RESP_OKAY, 32'(sum / (LR_THR_0 >> CF_SHIFT_LO))}, 32'hFFFFFFFF);
    cmp_word("steps", 34'(sum / LR_THR_0), 34'(steps_a + steps_b));
    cmp_bit("alternation", 1'b0, out_of_turn);
    $display("test pulses done");
    for (int i = 0; i < 8; i++)
    begin
      @(posedge aclk);
      rsel <= i[1:0];
      csel <= i[2];
      gsel <= i[0] ^ i[1];
      repeat (5) @(posedge aclk);
      cmp_bit("gain_x16", i[0] ^ i[1], gx16);
      rd(ADDR_STATUS, {RESP_OKAY, 23'h0, i[1:0], i[2], i[0] ^ i[1], 5'h0}, 32'hFFFFFFFF);
    end
    $display("test config done");
    @(posedge aclk);
    supply_low <= 1'b1;
    smp(24'h7FFFFF, 16'h03E8, 16'h0100);
    smp(24'h7FFFFF, 16'h03E8, 16'h0100);
    rd(ADDR_ENERGY, {RESP_OKAY, 32'(sum / (LR_THR_0 >> CF_SHIFT_LO))}, 32'hFFFFFFFF);
    rd(ADDR_STATUS, {RESP_OKAY, 32'h10}, 32'h10);
    cmp_word("steps", 34'(sum / LR_THR_0), 34'(steps_a + steps_b));
    $display("test undervoltage done");
    report_and_stop;
  end
endmodule
